/* File: logic/ees_pkg.sv */
// shared constants and types of the serial eeprom target
package ees_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam longint CLK_PERIOD_PS = 4000;                 // 250 mhz system clock
    localparam longint T_WRITE_NS    = 3000000;              // self-timed write, 3 ms
    // longest time, rounded down to whole cycles
    localparam int WRITE_CYCLES = int'((T_WRITE_NS * 1000) / CLK_PERIOD_PS);
    localparam int WCNT_W       = 20;

    // ************************************************************
    // address byte layout
    // ************************************************************
    localparam logic [3:0] TYPE_MAIN   = 4'ha;               // main storage
    localparam logic [3:0] TYPE_AUX    = 4'hb;               // id page, lock, protect, uid
    localparam int         TYPE_MSB    = 7;
    localparam int         TYPE_LSB    = 4;
    localparam int         CS_MSB      = 3;
    localparam int         CS_LSB      = 1;
    localparam int         RW_BIT      = 0;
    localparam int         AUX_SEL_MSB = 7;                  // word address selects aux item
    localparam int         AUX_SEL_LSB = 6;
    localparam logic [1:0] AUX_IDPAGE  = 2'h0;
    localparam logic [1:0] AUX_LOCK    = 2'h1;
    localparam logic [1:0] AUX_UID     = 2'h2;
    localparam logic [1:0] AUX_SWP     = 2'h3;

    // ************************************************************
    // storage
    // ************************************************************
    localparam int         BYTE_BITS  = 8;
    localparam int         PAGE_BYTES = 16;
    localparam int         PAGES      = 16;
    localparam int         MEM_BYTES  = PAGE_BYTES * PAGES;
    localparam logic [7:0] MEM_RESET  = 8'h00;
    // unique id contents; value is arbitrary
    localparam logic [127:0] UID_VALUE = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_RACK
    } ees_state_t;

    typedef enum logic [2:0] {
        TGT_MAIN,
        TGT_IDPAGE,
        TGT_LOCK,
        TGT_UID,
        TGT_SWP
    } ees_target_t;

endpackage

/* File: logic/ees_pin_sync.sv */
// pin synchroniser and bus condition detector of the serial eeprom target
`timescale 1ns/1ps

module ees_pin_sync (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [2:0] cs_i,
    input  wire logic       wp_i,
    output logic            sda_o,
    output logic [2:0]      cs_o,
    output logic            wp_o,
    output logic            scl_rise_o,
    output logic            scl_fall_o,
    output logic            start_o,
    output logic            stop_o
);

    typedef struct packed {
        logic [5:0] meta;   // first stage, read only by sync
        logic [5:0] sync;   // {wp, cs, sda, scl}
        logic       scl_q;
        logic       sda_q;
    } ees_sync_st_t;

    ees_sync_st_t st;
    ees_sync_st_t next_st;

    // ************************************************************
    // two-stage capture and edge history
    // ************************************************************
    always_comb begin
        next_st       = st;
        next_st.meta  = {wp_i, cs_i, sda_i, scl_i};
        next_st.sync  = st.meta;
        next_st.scl_q = st.sync[0];
        next_st.sda_q = st.sync[1];
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            // clock and data rest high, so no false edge follows reset
            st <= '{meta: 6'h03, sync: 6'h03, scl_q: 1'b1, sda_q: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    // data sampled on rising clock, output moved on falling clock
    assign scl_rise_o = st.sync[0] && !st.scl_q;
    assign scl_fall_o = !st.sync[0] && st.scl_q;
    // data edge while clock stays high is a start or stop, never a bit
    assign start_o    = st.sync[0] && st.scl_q && st.sda_q && !st.sync[1];
    assign stop_o     = st.sync[0] && st.scl_q && !st.sda_q && st.sync[1];
    assign sda_o      = st.sync[1];
    assign cs_o       = st.sync[4:2];
    assign wp_o       = st.sync[5];

endmodule

/* File: logic/ees_target.sv */
// two-wire serial eeprom target: protocol engine, storage and write timer
//
// Notes on behaviour
// - sample on clock rise, drive on fall
// - data pin is open drain only
// - open select inputs count as zero; this logic has no pull-downs, an open strap reads as unknown
// - three select inputs give eight addresses
// - protect input high blocks every change
// - open protect input counts as low; this logic has no pull-down, an open pin reads as unknown
// - protected writes: nack data, ack addresses
// - bytes travel most significant bit first
// - ninth clock carries acknowledge
// - data changes only while clock low
// - data edge in clock high: start/stop
// - device is target only
// - sixteen pages of sixteen bytes
// - byte and partial page writes
// - self-timed write within 3 ms
// - lockable sixteen byte id page
// - read-only 128-bit unique id
// - software protect flag guards array
// - stop after write starts write cycle
// - type codes 1010 and 1011
// - last address bit: 1 read, 0 write
// - ack on match, else nack and idle
`timescale 1ns/1ps

module ees_target #(
    parameter int WRITE_CYCLES = ees_pkg::WRITE_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic chip_select_bit0_i,
    input  wire logic chip_select_bit1_i,
    input  wire logic chip_select_bit2_i,
    input  wire logic write_protect_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    output logic      write_busy_o,
    output logic      id_page_locked_o,
    output logic      software_protect_flag_o
);

    typedef struct packed {
        ees_pkg::ees_state_t  state;
        logic [3:0]           bitcnt;
        logic [7:0]           shreg;
        logic [1:0]           byte_cnt;  // 0 device, 1 word address, 2 data
        logic                 rd;
        logic [7:0]           waddr;
        logic                 sda_oe;
        ees_pkg::ees_target_t tgt;
        logic [15:0][7:0]     buf_data;  // page buffer filled during a write
        logic [15:0]          buf_mask;
        logic [7:0]           buf_base;
        logic                 busy;
        logic [ees_pkg::WCNT_W-1:0] wcnt;
        logic                 lock;
        logic                 software_protect_flag;
        logic [255:0][7:0]    mem;
        logic [15:0][7:0]     idp;
    } ees_core_t;

    ees_core_t  st;
    ees_core_t  next_st;
    logic       sda_s;
    logic [2:0] cs_s;
    logic       wp_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       dev_match;
    logic       wr_block;
    logic [7:0] rd_byte;

    // ************************************************************
    // pin capture
    // ************************************************************
    // straps go straight into the synchroniser; nothing here pulls an undriven strap to zero
    ees_pin_sync u_sync (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .cs_i       ({chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i}),
        .wp_i       (write_protect_i),
        .sda_o      (sda_s),
        .cs_o       (cs_s),
        .wp_o       (wp_s),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (start),
        .stop_o     (stop)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    // next address: main storage runs on, aux items wrap in sixteen
    function automatic logic [7:0] step_addr(input ees_pkg::ees_target_t t,
                                             input logic [7:0] a);
        if (t == ees_pkg::TGT_MAIN) begin
            step_addr = a + 8'h01;
        end else begin
            step_addr = {a[7:4], a[3:0] + 4'h1};
        end
    endfunction

    // byte returned for the current target and address
    function automatic logic [7:0] read_byte(input ees_core_t s);
        logic [3:0] k;
        k = s.waddr[3:0];
        unique case (s.tgt)
            ees_pkg::TGT_MAIN:   read_byte = s.mem[s.waddr];
            ees_pkg::TGT_IDPAGE: read_byte = s.idp[k];
            ees_pkg::TGT_LOCK:   read_byte = {7'h00, s.lock};
            // factory id is a constant, most significant byte first
            ees_pkg::TGT_UID:    read_byte = ees_pkg::UID_VALUE[8'(127 - 8 * k) -: 8];
            ees_pkg::TGT_SWP:    read_byte = {7'h00, s.software_protect_flag};
        endcase
    endfunction

    // type code, select straps and idle write engine
    assign dev_match = (st.shreg[ees_pkg::TYPE_MSB:ees_pkg::TYPE_LSB] == ees_pkg::TYPE_MAIN ||
                        st.shreg[ees_pkg::TYPE_MSB:ees_pkg::TYPE_LSB] == ees_pkg::TYPE_AUX) &&
                       st.shreg[ees_pkg::CS_MSB:ees_pkg::CS_LSB] == cs_s && !st.busy;

    // protect pin, software flag and page lock
    assign wr_block = st.rd || st.tgt == ees_pkg::TGT_UID ||
                      (st.tgt == ees_pkg::TGT_SWP ? wp_s :
                       (wp_s || st.software_protect_flag || (st.tgt != ees_pkg::TGT_MAIN && st.lock)));

    assign rd_byte = read_byte(st);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st = st;
        // write cycle runs on its own timer, no bus needed
        if (st.busy) begin
            if (st.wcnt == '0) begin
                next_st.busy     = 1'b0;
                next_st.buf_mask = '0;
                for (int i = 0; i < ees_pkg::PAGE_BYTES; i++) begin
                    if (st.buf_mask[i]) begin
                        unique case (st.tgt)
                            ees_pkg::TGT_MAIN:   next_st.mem[{st.buf_base[7:4], 4'(i)}] =
                                                     st.buf_data[i];
                            ees_pkg::TGT_IDPAGE: next_st.idp[i] = st.buf_data[i];
                            ees_pkg::TGT_LOCK:   next_st.lock = 1'b1;
                            ees_pkg::TGT_SWP:    next_st.software_protect_flag  = st.buf_data[i][0];
                            default:             next_st.lock = st.lock;
                        endcase
                    end
                end
            end else begin
                next_st.wcnt = st.wcnt - 1'b1;
            end
        end

        // bus conditions override any byte in progress
        if (start) begin
            next_st.state    = ees_pkg::ST_RX;
            next_st.bitcnt   = '0;
            next_st.byte_cnt = 2'd0;
            next_st.sda_oe   = 1'b0;
        end else if (stop) begin
            next_st.state  = ees_pkg::ST_IDLE;
            next_st.sda_oe = 1'b0;
            // stop after accepted data starts the write cycle
            if (!st.busy && st.buf_mask != '0) begin
                next_st.busy = 1'b1;
                next_st.wcnt = ees_pkg::WCNT_W'(WRITE_CYCLES - 1);
            end
        end else begin
            unique case (st.state)
                ees_pkg::ST_IDLE: begin
                    next_st.sda_oe = 1'b0;
                end
                ees_pkg::ST_RX: begin
                    if (scl_rise && st.bitcnt != 4'd8) begin
                        // shift in msb first on rising clock
                        next_st.shreg  = {st.shreg[6:0], sda_s};
                        next_st.bitcnt = st.bitcnt + 4'd1;
                    end else if (scl_fall && st.bitcnt == 4'd8) begin
                        next_st.bitcnt = '0;
                        next_st.state  = ees_pkg::ST_ACK;
                        if (st.byte_cnt == 2'd0) begin
                            // address compare decides ack or standby
                            if (dev_match) begin
                                next_st.sda_oe   = 1'b1;
                                // last bit picks read or write
                                next_st.rd       = st.shreg[ees_pkg::RW_BIT];
                                next_st.byte_cnt = 2'd1;
                                if (st.shreg[ees_pkg::TYPE_LSB] == 1'b0) begin
                                    next_st.tgt = ees_pkg::TGT_MAIN;
                                end else if (st.tgt == ees_pkg::TGT_MAIN ||
                                             !st.shreg[ees_pkg::RW_BIT]) begin
                                    // aux write: item comes from the word address next,
                                    // aux read keeps the aux item chosen before, or takes id page after main
                                    next_st.tgt = ees_pkg::TGT_IDPAGE;
                                end
                            end else begin
                                next_st.state = ees_pkg::ST_IDLE;
                            end
                        end else if (st.byte_cnt == 2'd1) begin
                            // word address is always acknowledged
                            next_st.sda_oe   = 1'b1;
                            next_st.waddr    = st.shreg;
                            next_st.buf_base = st.shreg;
                            next_st.buf_mask = '0;
                            next_st.byte_cnt = 2'd2;
                            if (st.tgt != ees_pkg::TGT_MAIN || st.rd) begin
                                unique case (st.shreg[ees_pkg::AUX_SEL_MSB:ees_pkg::AUX_SEL_LSB])
                                    ees_pkg::AUX_IDPAGE: next_st.tgt = ees_pkg::TGT_IDPAGE;
                                    ees_pkg::AUX_LOCK:   next_st.tgt = ees_pkg::TGT_LOCK;
                                    ees_pkg::AUX_UID:    next_st.tgt = ees_pkg::TGT_UID;
                                    ees_pkg::AUX_SWP:    next_st.tgt = ees_pkg::TGT_SWP;
                                endcase
                            end
                        end else if (!wr_block) begin
                            // buffer byte, address wraps in page
                            next_st.sda_oe                       = 1'b1;
                            next_st.buf_data[st.waddr[3:0]]      = st.shreg;
                            next_st.buf_mask[st.waddr[3:0]]      = 1'b1;
                            next_st.waddr                        = {st.waddr[7:4],
                                                                    st.waddr[3:0] + 4'h1};
                        end
                        // protected data byte gets no ack
                    end
                end
                ees_pkg::ST_ACK: begin
                    // ack held through ninth clock, dropped on its fall
                    if (scl_fall) begin
                        if (st.rd) begin
                            next_st.state  = ees_pkg::ST_TX;
                            next_st.shreg  = rd_byte;
                            next_st.sda_oe = !rd_byte[7];
                            next_st.waddr  = step_addr(st.tgt, st.waddr);
                            next_st.rd     = 1'b1;
                        end else begin
                            next_st.state  = ees_pkg::ST_RX;
                            next_st.sda_oe = 1'b0;
                        end
                    end
                end
                ees_pkg::ST_TX: begin
                    // next bit on falling clock, low by pull only
                    if (scl_fall) begin
                        if (st.bitcnt == 4'd7) begin
                            next_st.state  = ees_pkg::ST_RACK;
                            next_st.sda_oe = 1'b0;
                        end else begin
                            next_st.shreg  = {st.shreg[6:0], 1'b0};
                            next_st.sda_oe = !st.shreg[6];
                            next_st.bitcnt = st.bitcnt + 4'd1;
                        end
                    end
                end
                ees_pkg::ST_RACK: begin
                    // master ack keeps reading, nack ends the read
                    if (scl_rise) begin
                        next_st.shreg[0] = sda_s;
                    end else if (scl_fall) begin
                        next_st.bitcnt = '0;
                        if (!st.shreg[0]) begin
                            next_st.state  = ees_pkg::ST_TX;
                            next_st.shreg  = rd_byte;
                            next_st.sda_oe = !rd_byte[7];
                            next_st.waddr  = step_addr(st.tgt, st.waddr);
                        end else begin
                            next_st.state = ees_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st       <= '0;
            st.state <= ees_pkg::ST_IDLE;
            st.tgt   <= ees_pkg::TGT_MAIN;
            st.mem   <= {ees_pkg::MEM_BYTES{ees_pkg::MEM_RESET}};
        end else begin
            st <= next_st;
        end
    end

    // pin only ever pulled low, never driven high
    assign sda_o                   = 1'b0;
    assign sda_oe_o                = st.sda_oe;
    assign write_busy_o            = st.busy;
    assign id_page_locked_o        = st.lock;
    assign software_protect_flag_o = st.software_protect_flag;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    localparam logic [ees_pkg::WCNT_W-1:0] WCNT_W_LOAD = ees_pkg::WCNT_W'(WRITE_CYCLES - 1);

    sequence s_stop_pending;
        stop && !st.busy && st.buf_mask != '0;
    endsequence

    sequence s_write_run;
        st.busy [*2] ##0 st.wcnt == WCNT_W_LOAD - 1;
    endsequence

    a_oe_on_fall: assert property ($changed(st.sda_oe) |->
        $past(scl_fall) || $past(start) || $past(stop))
        else $error("data pin changed away from a falling clock");

    a_ack_held: assert property (st.state == ees_pkg::ST_ACK && st.sda_oe &&
        !scl_fall && !start && !stop |=> st.sda_oe)
        else $error("acknowledge released inside the ninth clock");

    a_busy_nack: assert property (st.busy && st.state == ees_pkg::ST_RX &&
        st.byte_cnt == 2'd0 && scl_fall && st.bitcnt == 4'd8 && !start && !stop
        |=> !st.sda_oe && st.state == ees_pkg::ST_IDLE)
        else $error("address acknowledged during write cycle");

    a_protect_nack: assert property (wp_s && st.state == ees_pkg::ST_RX &&
        st.byte_cnt == 2'd2 && scl_fall && st.bitcnt == 4'd8 && !start && !stop
        |=> !st.sda_oe && $stable(st.buf_mask))
        else $error("data byte acknowledged while protected");

    a_mismatch_idle: assert property (st.state == ees_pkg::ST_RX &&
        st.byte_cnt == 2'd0 && scl_fall && st.bitcnt == 4'd8 && !dev_match &&
        !start && !stop |=> st.state == ees_pkg::ST_IDLE ##1 !st.sda_oe)
        else $error("no standby after address mismatch");

    a_start_resync: assert property (start |=>
        st.state == ees_pkg::ST_RX && st.bitcnt == 4'd0 && !st.sda_oe)
        else $error("start did not restart byte reception");

    a_stop_commit: assert property (s_stop_pending |=> s_write_run)
        else $error("stop after write did not start the write cycle");

    a_write_time: assert property ($fell(st.busy) |-> $past(st.wcnt) == '0)
        else $error("write cycle ended before its count");

    a_page_wrap: assert property ($changed(st.buf_mask) && st.buf_mask != '0
        |-> st.waddr[7:4] == $past(st.waddr[7:4]))
        else $error("write address left its page");

    a_tx_msb: assert property ($rose(st.state == ees_pkg::ST_TX) &&
        $past(st.state) == ees_pkg::ST_ACK |-> st.sda_oe == !st.shreg[7])
        else $error("read byte did not begin with its top bit");

endmodule

/* File: testbench/ees_bus_master.sv */
// two-wire bus controller model
`timescale 1ns/1ps

module ees_bus_master (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    // ****
    // bus phases
    // ****
    // idle: clock stands high, data released
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // quarter of a 125 ns bus clock
    task automatic q();
        #31.25;
    endtask
    task automatic start();
        sda_oe_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_oe_o = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_oe_o = 1'b0;
        q();
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_oe_o = ~b;
        q();
        scl_o = 1'b1;
        q();
        r = sda_i;
        q();
        scl_o = 1'b0;
        q();
    endtask
    task automatic byte_x(input logic [7:0] d, input logic ma,
                          output logic [7:0] r, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(ma, b);
        ack = ~b;
    endtask
endmodule

/* File: testbench/ees_target_tb.sv */
// self-checking bench of the serial eeprom target
`timescale 1ns/1ps

module ees_target_tb;
    localparam logic [3:0] MN = ees_pkg::TYPE_MAIN;
    localparam logic [3:0] AX = ees_pkg::TYPE_AUX;
    logic       clk_sys_i;
    logic       rst_n_i;
    logic [2:0] cs;
    logic       wp;
    logic       scl;
    logic       m_oe;
    logic       d_sda;
    logic       d_oe;
    logic       busy;
    logic       lock;
    logic       software_protect_flag;
    wire        sda;
    int         n_fail;
    int         check_count;
    int         k;
    logic [7:0] mem [256];
    logic [7:0] q [$];
    logic [7:0] b;
    logic [7:0] v;
    logic       a;
    // open-drain data line with pull-up
    assign sda = ~(m_oe | (d_oe & ~d_sda));
    ees_target #(.WRITE_CYCLES(2000)) i_dut (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .scl_i(scl),
        .sda_i(sda),
        .chip_select_bit0_i(cs[0]),
        .chip_select_bit1_i(cs[1]),
        .chip_select_bit2_i(cs[2]),
        .write_protect_i(wp),
        .sda_o(d_sda),
        .sda_oe_o(d_oe),
        .write_busy_o(busy),
        .id_page_locked_o(lock),
        .software_protect_flag_o(software_protect_flag)
    );
    ees_bus_master i_bm (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    // ****
    // checks and bus tasks
    // ****
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // start, device byte, word address
    task automatic hdr(input logic [3:0] t, input logic [7:0] w);
        i_bm.start();
        i_bm.byte_x({t, cs, 1'b0}, 1'b1, b, a);
        chk1(a, 1'b1);
        i_bm.byte_x(w, 1'b1, b, a);
        chk1(a, 1'b1);
    endtask
    task automatic wr(input logic [3:0] t, input logic [7:0] w, input logic [7:0] d[$],
                      input logic ea);
        hdr(t, w);
        foreach (d[i]) begin
            i_bm.byte_x(d[i], 1'b1, b, a);
            chk1(a, ea);
        end
        i_bm.stop();
    endtask
    // poll until the device byte is acknowledged, bounded
    task automatic poll();
        k = 0;
        a = 1'b0;
        while (a !== 1'b1) begin
            if (++k > 30) begin
                n_fail++;
                print_verdict();
            end
            i_bm.start();
            i_bm.byte_x({MN, cs, 1'b0}, 1'b1, b, a);
            i_bm.stop();
        end
    endtask
    task automatic rd(input logic [3:0] t, input logic [7:0] w, input int n);
        hdr(t, w);
        i_bm.start();
        i_bm.byte_x({t, cs, 1'b1}, 1'b1, b, a);
        chk1(a, 1'b1);
        q = {};
        for (int i = 0; i < n; i++) begin
            i_bm.byte_x(8'hff, i == n - 1, b, a);
            q.push_back(b);
        end
        i_bm.stop();
    endtask
    // main write of n random bytes, then compare the whole page
    task automatic wmain(input logic [7:0] ad, input int n, input logic ea);
        logic [7:0] d[$];
        for (int i = 0; i < n; i++) begin
            d.push_back(8'($urandom));
            if (ea) begin
                mem[{ad[7:4], ad[3:0] + 4'(i)}] = d[i];
            end
        end
        wr(MN, ad, d, ea);
        chk1(busy, ea);
        poll();
        chk1(k > 1, ea);
        chk1(busy, 1'b0);
        rd(MN, {ad[7:4], 4'h0}, 16);
        foreach (q[i]) begin
            chk8(q[i], mem[{ad[7:4], 4'(i)}]);
        end
    endtask
    // ****
    // clock and tests
    // ****
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        n_fail = 0;
        check_count = 0;
        rst_n_i = 1'b0;
        wp = 1'b0;
        void'($urandom(32'h0ec0));
        cs = 3'($urandom);
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        for (int c = 0; c < 8; c++) begin
            i_bm.start();
            i_bm.byte_x({MN, 3'(c), 1'b0}, 1'b1, b, a);
            i_bm.stop();
            chk1(a, 3'(c) == cs);
        end
        $display("select test done");
        wmain({4'($urandom), 4'he}, 4, 1'b1);
        repeat (3) wmain(8'($urandom), 1 + $urandom % 16, 1'b1);
        $display("write test done");
        @(posedge clk_sys_i) wp <= 1'b1;
        wmain(8'($urandom), 2, 1'b0);
        @(posedge clk_sys_i) wp <= 1'b0;
        $display("protect pin test done");
        wr(AX, 8'hc0, {8'h01}, 1'b1);
        poll();
        chk1(software_protect_flag, 1'b1);
        wmain(8'($urandom), 1, 1'b0);
        wr(AX, 8'hc0, {8'h00}, 1'b1);
        poll();
        chk1(software_protect_flag, 1'b0);
        $display("protect flag test done");
        rd(AX, 8'h80, 2);
        chk8(q[0], ees_pkg::UID_VALUE[127:120]);
        chk8(q[1], ees_pkg::UID_VALUE[119:112]);
        $display("unique id test done");
        v = 8'($urandom);
        wr(AX, 8'h03, {v}, 1'b1);
        poll();
        wr(AX, 8'h40, {8'h00}, 1'b1);
        poll();
        chk1(lock, 1'b1);
        wr(AX, 8'h03, {~v}, 1'b0);
        poll();
        rd(AX, 8'h03, 1);
        chk8(q[0], v);
        $display("id page test done");
        print_verdict();
    end
endmodule
